// File: rtl/delw_logout.sv
// Decided for this implementation: the plain strobed port and the placing of the registers.
`timescale 1ns/100ps
`default_nettype none
`include "delw_cfg.svh"
module delw_logout #(
	parameter int DATA_W = 16,
	parameter int NREG = 8
)(
	// clock, reset, enable
	input wire logic clk_sys,
	input wire logic resetn,
	input wire logic clk_en,
	// element side
	input wire logic [3:0] tag_in,
	input wire logic tag_valid,
	input wire logic tag_mismatch,
	input wire logic tag_parity_chk,
	input wire logic [2:0] generator_position,
	input wire logic [NREG*DATA_W-1:0] generator_data,
	input wire logic [NREG-1:0] generator_reg_chk,
	input wire logic [2:0] halfword_index,
	// logout request from a computing element
	input wire logic logout_req,
	input wire logic [3:0] logout_target,
	input wire logic [31:0] logout_word_in,
	// main storage write port
	output logic store_wr,
	output logic [31:0] store_addr,
	output logic [31:0] store_data,
	// register port
	input wire delw_pkg::delw_addr_type reg_addr,
	input wire logic [31:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [31:0] reg_rdata,
	// interrupt
	output logic irq
);
	import delw_pkg::*;

	// elaboration-time guard: register map and packed word assume these sizes
	if (DATA_W != 16 || NREG != 8)
	begin
		$error("delw_logout supports DATA_W=16 and NREG=8 only");
	end

	logic [3:0] tag, next_tag;
	logic [3:0] hw_cnt, next_hw_cnt;
	logic [DATA_W-1:0] gen_data, next_gen_data;
	logic [NREG-1:0] reg_chk, next_reg_chk;
	logic frozen, next_frozen;
	logic [`DELW_ST_W-1:0] status, next_status, mask, next_mask;
	logic [31:0] log_base, next_log_base;
	delw_state_type state, next_state;
	logic [3:0] widx, next_widx;
	logic store_wr_q, next_store_wr;
	logic [31:0] store_addr_q, next_store_addr, store_data_q, next_store_data;
	logic [31:0] rdata, next_rdata;
	logic irq_q, next_irq;
	logic [3:0] elem_id;
	logic [DATA_W-1:0] sel_data;
	logic [31:0] final_word;
	logic any_chk;

	// element number code from plugged generator position
	always_comb
	begin
		elem_id = 4'h0;
		if (generator_position != 3'h0 && generator_position <= `DELW_ID_MAX)
			elem_id = `DELW_ID_BASE + {1'b0, generator_position} - 4'h1;
	end

	// pick the lowest-numbered generator register in check
	always_comb
	begin
		sel_data = '0;
		for (int i = NREG - 1; i >= 0; i--)
			if (generator_reg_chk[i])
				sel_data = generator_data[i*DATA_W +: DATA_W];
	end

	assign any_chk = tag_mismatch | tag_parity_chk | (|generator_reg_chk);
	// bits 19:16 are spare and read zero
	assign final_word = {tag, elem_id, hw_cnt, 4'h0, gen_data};

	always_comb
	begin
		next_tag = tag;
		next_hw_cnt = hw_cnt;
		next_gen_data = gen_data;
		next_reg_chk = reg_chk;
		next_frozen = frozen;
		next_status = status;
		next_mask = mask;
		next_log_base = log_base;
		next_state = state;
		next_widx = widx;
		next_store_wr = 1'b0;
		next_store_addr = store_addr_q;
		next_store_data = store_data_q;
		next_rdata = 32'h0;
		// software clear of the freeze comes first so a same-cycle check re-freezes
		if (reg_wr && reg_addr == `DELW_OFF_CTRL && reg_wdata[0])
		begin
			next_frozen = 1'b0;
			next_reg_chk = '0;
			next_gen_data = '0;
		end
		if (!next_frozen)
		begin
			if (tag_valid)
				next_tag = tag_in;
			next_hw_cnt = `DELW_HW_BASE + {1'b0, halfword_index};
			if (|generator_reg_chk)
			begin
				next_gen_data = sel_data;
				next_reg_chk = generator_reg_chk;
			end
			if (any_chk)
				next_frozen = 1'b1;
		end
		if (reg_wr && reg_addr == `DELW_OFF_STATUS)
			next_status = status & ~reg_wdata[`DELW_ST_W-1:0];
		if (reg_wr && reg_addr == `DELW_OFF_MASK)
			next_mask = reg_wdata[`DELW_ST_W-1:0];
		if (reg_wr && reg_addr == `DELW_OFF_LOGADDR)
			next_log_base = reg_wdata;
		// logout sequencer: twelve words, last one is the packed word
		case (state)
			delw_idle_type_e:
			begin
				if (logout_req && logout_target == elem_id && elem_id != 4'h0)
				begin
					next_state = delw_write_type_e;
					next_widx = 4'h0;
				end
			end
			delw_write_type_e:
			begin
				next_store_wr = 1'b1;
				next_store_addr = log_base + {26'h0, widx, 2'b00};
				next_store_data = (widx == `DELW_LAST_WORD) ? final_word : logout_word_in;
				if (widx == `DELW_LAST_WORD)
				begin
					next_state = delw_idle_type_e;
					next_status[`DELW_ST_DONE] = 1'b1;
				end
				next_widx = widx + 4'h1;
			end
			default: next_state = delw_idle_type_e;
		endcase
		// hardware set wins over a clear in the same cycle
		if (tag_mismatch | tag_parity_chk)
			next_status[`DELW_ST_TAG] = 1'b1;
		if (|generator_reg_chk)
			next_status[`DELW_ST_REG] = 1'b1;
		if (reg_rd)
		begin
			case (reg_addr)
				`DELW_OFF_WORD: next_rdata = final_word;
				`DELW_OFF_CHECKS: next_rdata = {23'h0, frozen, reg_chk};
				`DELW_OFF_STATUS: next_rdata = {29'h0, status};
				`DELW_OFF_MASK: next_rdata = {29'h0, mask};
				`DELW_OFF_LOGADDR: next_rdata = log_base;
				default: next_rdata = 32'h0;
			endcase
		end
		next_irq = |(next_status & next_mask);
	end

	always_ff @(posedge clk_sys or negedge resetn)
	begin
		if (!resetn)
		begin
			tag <= 4'h0;
			hw_cnt <= `DELW_HW_BASE;
			gen_data <= '0;
			reg_chk <= '0;
			frozen <= 1'b0;
			status <= '0;
			mask <= '0;
			log_base <= 32'h0;
			state <= delw_idle_type_e;
			widx <= 4'h0;
			store_wr_q <= 1'b0;
			store_addr_q <= 32'h0;
			store_data_q <= 32'h0;
			rdata <= 32'h0;
			irq_q <= 1'b0;
		end
		else if (clk_en)
		begin
			tag <= next_tag;
			hw_cnt <= next_hw_cnt;
			gen_data <= next_gen_data;
			reg_chk <= next_reg_chk;
			frozen <= next_frozen;
			status <= next_status;
			mask <= next_mask;
			log_base <= next_log_base;
			state <= next_state;
			widx <= next_widx;
			store_wr_q <= next_store_wr;
			store_addr_q <= next_store_addr;
			store_data_q <= next_store_data;
			rdata <= next_rdata;
			irq_q <= next_irq;
		end
	end

	assign store_wr = store_wr_q;
	assign store_addr = store_addr_q;
	assign store_data = store_data_q;
	assign reg_rdata = rdata;
	assign irq = irq_q;
endmodule
`default_nettype wire

// File: rtl/delw_cfg.svh
`ifndef DELW_CFG_SVH
`define DELW_CFG_SVH
// register map of the plain register port
`define DELW_ADDR_W 4
`define DELW_OFF_WORD 4'h0
`define DELW_OFF_CHECKS 4'h1
`define DELW_OFF_STATUS 4'h2
`define DELW_OFF_MASK 4'h3
`define DELW_OFF_CTRL 4'h4
`define DELW_OFF_LOGADDR 4'h5
// logout word field positions
`define DELW_TAG_LSB 28
`define DELW_ID_LSB 24
`define DELW_HW_LSB 20
// element number: generator positions 1..5 map to codes 6..a
`define DELW_ID_BASE 4'h6
`define DELW_ID_MAX 3'h5
// halfword counter: halfword indexes 0..7 map to counts 8..f
`define DELW_HW_BASE 4'h8
// logout: six doublewords are twelve words
`define DELW_LOG_WORDS 4'hc
`define DELW_LAST_WORD 4'hb
// status bits
`define DELW_ST_TAG 0
`define DELW_ST_REG 1
`define DELW_ST_DONE 2
`define DELW_ST_W 3
`endif

// File: rtl/delw_pkg.sv
`default_nettype none
package delw_pkg;
	typedef enum logic [1:0] {delw_idle_type_e, delw_write_type_e} delw_state_type;
	typedef logic [3:0] delw_addr_type;
endpackage
`default_nettype wire

// File: bench/delw_asserts.sv
`timescale 1ns/100ps
`default_nettype none
module delw_asserts (
	// clock, reset
	input wire logic clk_sys,
	input wire logic resetn,
	// watched ports
	input wire logic [2:0] generator_position,
	input wire logic logout_req,
	input wire logic [31:0] logout_word_in,
	input wire logic store_wr,
	input wire logic [31:0] store_addr,
	input wire logic [31:0] store_data
);
	default clocking @(posedge clk_sys); endclocking
	default disable iff (!resetn);
	property p_tr; $rose(store_wr) |-> store_wr[*8] ##1 store_wr[*4] ##1 !store_wr; endproperty
	a_tr: assert property (p_tr) else $error("pulse count");
	property p_ad; store_wr && $past(store_wr) |-> store_addr == $past(store_addr) + 32'h4; endproperty
	a_ad: assert property (p_ad) else $error("address step");
	property p_go; $rose(store_wr) |-> $past(logout_req, 2); endproperty
	a_go: assert property (p_go) else $error("start");
	property p_dt; store_wr && $past(store_wr) |-> $past(store_data) == $past(logout_word_in, 2); endproperty
	a_dt: assert property (p_dt) else $error("word data");
	// a fresh burst may follow after one idle cycle, but only after a new request
	property p_gp; $fell(store_wr) && !$past(logout_req) |-> !store_wr ##1 !store_wr; endproperty
	a_gp: assert property (p_gp) else $error("restart");
	// the last word is the one just before the fall
	property p_id; $fell(store_wr) && generator_position inside {[3'h1:3'h5]} |->
		$past(store_data[27:24]) == {1'b0, generator_position} + 4'h5; endproperty
	a_id: assert property (p_id) else $error("element number");
	property p_pk; $fell(store_wr) |-> $past(store_data[19:16]) == 4'h0; endproperty
	a_pk: assert property (p_pk) else $error("packing");
	property p_hw; $fell(store_wr) |-> $past(store_data[23]); endproperty
	a_hw: assert property (p_hw) else $error("halfword count");
endmodule
bind delw_logout delw_asserts chk (.clk_sys, .resetn, .generator_position, .logout_req,
	.logout_word_in, .store_wr, .store_addr, .store_data);
`default_nettype wire

// File: bench/delw_ce_model.sv
`timescale 1ns/100ps
`default_nettype none
module delw_ce_model (
	// clock
	input wire logic clk_sys,
	// logout request
	output logic logout_req = 1'b0,
	output logic [3:0] logout_target = 4'h0,
	output logic [31:0] logout_word_in = 32'hc0de0000,
	// main storage writes
	input wire logic store_wr,
	input wire logic [31:0] store_addr,
	input wire logic [31:0] store_data
);
	logic [31:0] mem [16];
	int n_wr = 0;
	// a fresh word every cycle, so a late or early sample shows
	always @(posedge clk_sys)
	begin
		logout_word_in <= logout_word_in + 32'h1;
		if (store_wr && store_addr[31:6] == 26'h4)
		begin
			mem[store_addr[5:2]] <= store_data;
			n_wr <= n_wr + 1;
		end
	end
	task automatic request(input logic [3:0] tgt);
		@(posedge clk_sys);
		logout_req <= 1'b1;
		logout_target <= tgt;
		@(posedge clk_sys);
		logout_req <= 1'b0;
		logout_target <= ~tgt;
	endtask
endmodule
`default_nettype wire

// File: bench/testbench.sv
`timescale 1ns/100ps
`default_nettype none
`include "delw_cfg.svh"
module testbench;
	import delw_pkg::*;
	logic clk_sys = 1'b0;
	logic resetn = 1'b0;
	logic [3:0] tag_in = 4'h9;
	logic tag_valid = 1'b1;
	logic tag_mismatch = 1'b0;
	logic tag_parity_chk = 1'b0;
	logic clk_en = 1'b1;
	logic [2:0] generator_position = 3'h3;
	logic [127:0] generator_data = 128'h1007_1006_1005_1004_1003_1002_1001_1000;
	logic [7:0] generator_reg_chk = 8'h0;
	logic [2:0] halfword_index = 3'h5;
	logic logout_req, store_wr, irq, reg_wr = 1'b0, reg_rd = 1'b0;
	logic [3:0] logout_target;
	logic [31:0] logout_word_in, store_addr, store_data, reg_rdata, reg_wdata = 32'h0;
	delw_addr_type reg_addr = 4'h0;
	int n_fail = 0;
	int tests_run = 0;
	initial forever #2 clk_sys = ~clk_sys;
	delw_logout dut (.clk_sys, .resetn, .clk_en, .tag_in, .tag_valid, .tag_mismatch,
		.tag_parity_chk, .generator_position, .generator_data, .generator_reg_chk,
		.halfword_index, .logout_req, .logout_target, .logout_word_in, .store_wr,
		.store_addr, .store_data, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .irq);
	delw_ce_model ce (.clk_sys, .logout_req, .logout_target, .logout_word_in, .store_wr,
		.store_addr, .store_data);
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		tests_run++;
		if (got !== exp)
		begin
			n_fail++;
			$display("MISMATCH %0t got %h exp %h", $time, got, exp);
		end
	endtask
	task automatic wr(input delw_addr_type a, input logic [31:0] d);
		@(posedge clk_sys);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge clk_sys);
		reg_wr <= 1'b0;
	endtask
	task automatic rd(input delw_addr_type a, input logic [31:0] e);
		@(posedge clk_sys);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge clk_sys);
		reg_rd <= 1'b0;
		#1 chk(reg_rdata, e);
	endtask
	task automatic conclude();
		$display("checks %0d mismatches %0d", tests_run, n_fail);
		if (n_fail == 0 && tests_run > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask
	initial
	begin
		#5000;
		n_fail++;
		conclude();
	end
	initial
	begin
		repeat (5) @(posedge clk_sys);
		resetn <= 1'b1;
		rd(`DELW_OFF_STATUS, 32'h0);
		rd(4'hf, 32'h0);
		wr(`DELW_OFF_LOGADDR, 32'h100);
		wr(`DELW_OFF_MASK, 32'h2);
		ce.request(4'h9);
		repeat (16) @(posedge clk_sys);
		chk(ce.n_wr, 32'h0);
		ce.request(4'h8);
		repeat (16) @(posedge clk_sys);
		chk(ce.n_wr, 32'hc);
		chk(ce.mem[11], 32'h98d0_0000);
		rd(`DELW_OFF_STATUS, 32'h4);
		chk({31'h0, irq}, 32'h0);
		@(posedge clk_sys);
		generator_reg_chk <= 8'h24;
		tag_mismatch <= 1'b1;
		@(posedge clk_sys);
		generator_reg_chk <= 8'h0;
		tag_mismatch <= 1'b0;
		tag_in <= 4'h3;
		halfword_index <= 3'h1;
		generator_data <= '0;
		repeat (3) @(posedge clk_sys);
		#1 chk({31'h0, irq}, 32'h1);
		rd(`DELW_OFF_WORD, 32'h98d0_1002);
		rd(`DELW_OFF_CHECKS, 32'h124);
		wr(`DELW_OFF_STATUS, 32'h7);
		wr(`DELW_OFF_CTRL, 32'h1);
		rd(`DELW_OFF_WORD, 32'h3890_0000);
		chk({31'h0, irq}, 32'h0);
		// a parity check alone freezes the tag it arrived with
		@(posedge clk_sys);
		tag_parity_chk <= 1'b1;
		tag_in <= 4'h5;
		@(posedge clk_sys);
		tag_parity_chk <= 1'b0;
		tag_in <= 4'h6;
		rd(`DELW_OFF_WORD, 32'h5890_0000);
		rd(`DELW_OFF_STATUS, 32'h1);
		rd(`DELW_OFF_CHECKS, 32'h100);
		// a write while the clock enable is low must not land
		@(posedge clk_sys);
		clk_en <= 1'b0;
		wr(`DELW_OFF_MASK, 32'h7);
		clk_en <= 1'b1;
		rd(`DELW_OFF_MASK, 32'h2);
		conclude();
	end
endmodule
`default_nettype wire
